// [hw/hcs_pkg.sv]
package hcs_pkg;

   localparam logic [7:0] CMD_OFFSET  = 8'h20;
   localparam logic [7:0] STS_OFFSET  = 8'h24;

   // Command register fields
   localparam int CMD_RS_BIT   = 0;
   localparam int CMD_RST_BIT  = 1;
   localparam int CMD_FLS_LSB  = 2;

   // Status register fields
   localparam int STS_EVT_LSB  = 0;
   localparam int STS_HSE_BIT  = 4;
   localparam int STS_HCH_BIT  = 12;
   localparam int STS_RECL_BIT = 13;
   localparam int STS_PSS_BIT  = 14;
   localparam int STS_ASS_BIT  = 15;

   localparam int EVT_W        = 6;

   localparam logic [1:0] FLS_1024   = 2'h0;
   localparam logic [1:0] FLS_512    = 2'h1;
   localparam logic [1:0] FLS_256    = 2'h2;
   localparam logic [1:0] FLS_RSVD   = 2'h3;
   localparam logic [1:0] FLS_RESET  = FLS_1024;
   localparam logic       HCH_RESET  = 1'h1;

   localparam int FIDX_W       = 14;
   localparam int LIST_IDX_W   = 10;
   localparam int RST_CYCLES   = 16;

   typedef enum logic [1:0] {
      HCS_HALTED   = 2'h0,
      HCS_RUNNING  = 2'h1,
      HCS_STOPPING = 2'h3,
      HCS_RESET    = 2'h2
   } hcs_state_type;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } hcs_req_type;

   typedef struct packed {
      logic       async_status;
      logic       periodic_status;
      logic       reclamation;
   } hcs_sched_type;

endpackage

// [hw/hcs_cmd_status.sv]
// Function
// - List size resets 00b; 1024/512/256, 11b reserved
// - List size writable only when capability set
// - List size picks frame index bits used
// - Soft reset reinitialises pipelines, timers, state machines
// - Soft reset aborts bus transaction immediately
// - Soft reset drives no downstream bus reset
// - Soft reset leaves configuration space untouched
// - Soft reset clears operational regs, releases ports
// - Reset bit self-clears when reset finishes
// - Writing zero cannot cut reset short
// - Run/stop one runs schedule, zero stops
// - Clearing run/stop drains pipeline, then halts
// - Status flags clear by writing one
// - Status holds no per-transaction results
// - Status register decoded at offset 24h
// - Halted resets one, zero while running
// - Host system error clears run/stop
`timescale 1ns/100ps
`default_nettype none
module hcs_cmd_status #(
   parameter int RST_CYCLES = hcs_pkg::RST_CYCLES
) (
   input  wire logic                               clock_i,
   input  wire logic                               nrst_i,
   input  wire hcs_pkg::hcs_req_type               reg_req_i,
   output logic [31:0]                             reg_rdata_o,
   output logic                                    reg_rvalid_o,
   input  wire logic                               programmable_list_capable_i,
   input  wire logic [hcs_pkg::EVT_W-1:0]          status_event_i,
   input  wire logic                               host_system_error_i,
   input  wire hcs_pkg::hcs_sched_type             sched_status_i,
   input  wire logic                               pipeline_idle_i,
   input  wire logic [hcs_pkg::FIDX_W-1:0]         frame_index_i,
   output logic [hcs_pkg::LIST_IDX_W-1:0]          frame_list_index_o,
   output logic [1:0]                              frame_list_size_o,
   output logic                                    schedule_run_o,
   output logic                                    soft_reset_o,
   output logic                                    abort_transfer_o,
   output logic                                    port_release_o
);

   hcs_pkg::hcs_state_type state_ff;
   hcs_pkg::hcs_state_type nxt_state;

   logic                        run_stop_ff;
   logic                        nxt_run_stop;
   logic [1:0]                  fls_ff;
   logic [1:0]                  nxt_fls;
   logic                        halted_ff;
   logic [hcs_pkg::EVT_W-1:0]   flags_ff;
   logic [hcs_pkg::EVT_W-1:0]   nxt_flags;
   logic [15:0]                 rst_cnt_ff;
   logic [15:0]                 nxt_rst_cnt;
   logic [31:0]                 rdata_ff;
   logic                        rvalid_ff;
   logic                        abort_ff;

   wire       resetting = (state_ff == hcs_pkg::HCS_RESET);
   wire       cmd_wr    = reg_req_i.wr &&
                          (reg_req_i.addr == hcs_pkg::CMD_OFFSET);
   wire       sts_wr    = reg_req_i.wr &&
                          (reg_req_i.addr == hcs_pkg::STS_OFFSET);
   wire       rst_req   = cmd_wr && !resetting &&
                          reg_req_i.wdata[hcs_pkg::CMD_RST_BIT];
   wire       rst_done  = resetting &&
                          (rst_cnt_ff == 16'(RST_CYCLES - 1));
   wire [1:0] wr_fls    = reg_req_i.wdata[hcs_pkg::CMD_FLS_LSB +: 2];
   wire       fls_ok    = programmable_list_capable_i &&
                          (wr_fls != hcs_pkg::FLS_RSVD);

   // Every write is ignored mid-reset, so a zero to the reset bit is too
   wire       cmd_take  = cmd_wr && !resetting && !rst_req;

   wire [hcs_pkg::EVT_W-1:0] w1c =
      sts_wr ? reg_req_i.wdata[hcs_pkg::STS_EVT_LSB +: hcs_pkg::EVT_W]
             : '0;

   always_comb
   begin
      nxt_state    = state_ff;
      nxt_run_stop = run_stop_ff;
      nxt_fls      = fls_ff;
      nxt_rst_cnt  = 16'h0000;
      if (cmd_take)
      begin
         nxt_run_stop = reg_req_i.wdata[hcs_pkg::CMD_RS_BIT];
         if (fls_ok)
            nxt_fls = wr_fls;
      end
      if (host_system_error_i)
         nxt_run_stop = 1'b0;
      case (state_ff)
         hcs_pkg::HCS_HALTED:
            if (nxt_run_stop)
               nxt_state = hcs_pkg::HCS_RUNNING;
         hcs_pkg::HCS_RUNNING:
            if (!nxt_run_stop)
               nxt_state = hcs_pkg::HCS_STOPPING;
         hcs_pkg::HCS_STOPPING:
            if (pipeline_idle_i)
               nxt_state = hcs_pkg::HCS_HALTED;
         hcs_pkg::HCS_RESET:
         begin
            nxt_rst_cnt  = rst_cnt_ff + 16'h0001;
            nxt_run_stop = 1'b0;
            nxt_fls      = hcs_pkg::FLS_RESET;
            if (rst_done)
               nxt_state = hcs_pkg::HCS_HALTED;
         end
         default:
            nxt_state = hcs_pkg::HCS_HALTED;
      endcase
      // Reset always overrides; software should only ask when halted
      if (rst_req)
      begin
         nxt_state    = hcs_pkg::HCS_RESET;
         nxt_run_stop = 1'b0;
         nxt_fls      = hcs_pkg::FLS_RESET;
         nxt_rst_cnt  = 16'h0000;
      end
   end

   // Set beats a simultaneous write-one clear
   always_comb
   begin
      nxt_flags = (flags_ff & ~w1c) | status_event_i;
      nxt_flags[hcs_pkg::STS_HSE_BIT] = host_system_error_i ||
         (flags_ff[hcs_pkg::STS_HSE_BIT] && !w1c[hcs_pkg::STS_HSE_BIT]);
      if (resetting || rst_req)
         nxt_flags = '0;
   end

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         state_ff    <= hcs_pkg::HCS_HALTED;
         run_stop_ff <= 1'b0;
         fls_ff      <= hcs_pkg::FLS_RESET;
         halted_ff   <= hcs_pkg::HCH_RESET;
         flags_ff    <= '0;
         rst_cnt_ff  <= 16'h0000;
         abort_ff    <= 1'b0;
      end
      else
      begin
         state_ff    <= nxt_state;
         run_stop_ff <= nxt_run_stop;
         fls_ff      <= nxt_fls;
         halted_ff   <= (nxt_state == hcs_pkg::HCS_HALTED) ||
                        (nxt_state == hcs_pkg::HCS_RESET);
         flags_ff    <= nxt_flags;
         rst_cnt_ff  <= nxt_rst_cnt;
         abort_ff    <= rst_req;
      end
   end

   // Status carries only controller-level state and causes
   wire [31:0] sts_word = {16'h0000,
                           sched_status_i.async_status,
                           sched_status_i.periodic_status,
                           sched_status_i.reclamation,
                           halted_ff,
                           6'h00,
                           flags_ff};
   wire [31:0] cmd_word = {28'h0000000, fls_ff, resetting, run_stop_ff};
   wire [31:0] rd_mux   =
      (reg_req_i.addr == hcs_pkg::CMD_OFFSET) ? cmd_word :
      (reg_req_i.addr == hcs_pkg::STS_OFFSET) ? sts_word : 32'h00000000;

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         rdata_ff  <= 32'h00000000;
         rvalid_ff <= 1'b0;
      end
      else
      begin
         rdata_ff  <= reg_req_i.rd ? rd_mux : rdata_ff;
         rvalid_ff <= reg_req_i.rd;
      end
   end

   // Index width follows list size: bits 12:3, 11:3 or 10:3
   wire [hcs_pkg::LIST_IDX_W-1:0] idx_full = frame_index_i[12:3];
   assign frame_list_index_o =
      (fls_ff == hcs_pkg::FLS_512) ? {1'b0, idx_full[8:0]} :
      (fls_ff == hcs_pkg::FLS_256) ? {2'h0, idx_full[7:0]} :
                                     idx_full;

   assign frame_list_size_o = fls_ff;
   assign reg_rdata_o       = rdata_ff;
   assign reg_rvalid_o      = rvalid_ff;
   assign schedule_run_o    = (state_ff == hcs_pkg::HCS_RUNNING);
   // Internal-only reset; port bus reset and config space not driven here
   assign soft_reset_o      = resetting;
   assign abort_transfer_o  = abort_ff;
   assign port_release_o    = resetting;

endmodule
`default_nettype wire

// [dv/hcs_cmd_status_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module hcs_cmd_status_checker #(
   parameter int RST_CYCLES = 16
) (
   input wire logic                          clock_i,
   input wire logic                          nrst_i,
   input wire hcs_pkg::hcs_req_type          reg_req_i,
   input wire logic [31:0]                   reg_rdata_o,
   input wire logic                          reg_rvalid_o,
   input wire logic                          programmable_list_capable_i,
   input wire logic                          host_system_error_i,
   input wire logic [hcs_pkg::FIDX_W-1:0]    frame_index_i,
   input wire logic [hcs_pkg::LIST_IDX_W-1:0] frame_list_index_o,
   input wire logic [1:0]                    frame_list_size_o,
   input wire logic                          schedule_run_o,
   input wire logic                          soft_reset_o,
   input wire logic                          abort_transfer_o,
   input wire logic                          port_release_o
);
   localparam int RM = RST_CYCLES - 1;
   wire logic rd_sts;
   assign rd_sts = reg_req_i.rd && reg_req_i.addr == hcs_pkg::STS_OFFSET;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   chk_read_answered: assert property (reg_req_i.rd |=> reg_rvalid_o)
      else $error("read not answered");
   chk_sts_reserved: assert property (rd_sts |=>
      reg_rdata_o[31:16] == 16'h0 && reg_rdata_o[11:6] == 6'h0)
      else $error("status reserved bits set");
   chk_size_legal: assert property (
      frame_list_size_o != hcs_pkg::FLS_RSVD) else $error("size reserved");
   chk_size_locked: assert property (!programmable_list_capable_i |=>
      $stable(frame_list_size_o) || soft_reset_o) else $error("size moved");
   chk_index_full: assert property (frame_list_size_o == hcs_pkg::FLS_1024 |->
      frame_list_index_o == frame_index_i[12:3]) else $error("index 1024");
   chk_index_small: assert property (frame_list_size_o == hcs_pkg::FLS_256 |->
      frame_list_index_o == {2'h0, frame_index_i[10:3]})
      else $error("index 256");
   chk_abort_start: assert property (
      $rose(soft_reset_o) |-> abort_transfer_o) else $error("no abort");
   chk_port_release: assert property (
      port_release_o == soft_reset_o) else $error("ports kept");
   chk_reset_quiet: assert property (
      soft_reset_o |-> !schedule_run_o) else $error("runs in reset");
   chk_reset_length: assert property ($rose(soft_reset_o) |->
      ##RM soft_reset_o ##1 !soft_reset_o) else $error("reset length");
   chk_error_stops: assert property (
      host_system_error_i |=> !schedule_run_o) else $error("error kept run");
endmodule
bind hcs_cmd_status hcs_cmd_status_checker #(.RST_CYCLES(RST_CYCLES)) chk_inst (
   .clock_i(clock_i), .nrst_i(nrst_i), .reg_req_i(reg_req_i),
   .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
   .programmable_list_capable_i(programmable_list_capable_i),
   .host_system_error_i(host_system_error_i), .frame_index_i(frame_index_i),
   .frame_list_index_o(frame_list_index_o),
   .frame_list_size_o(frame_list_size_o), .schedule_run_o(schedule_run_o),
   .soft_reset_o(soft_reset_o), .abort_transfer_o(abort_transfer_o),
   .port_release_o(port_release_o));
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic                 clock_i = 1'b0;
   logic                 nrst_i = 1'b0;
   hcs_pkg::hcs_req_type req = '0;
   logic                 cap = 1'b1;
   logic [5:0]           evt = 6'h0;
   logic                 host_system_error = 1'b0;
   logic                 idle = 1'b1;
   logic [13:0]          fidx = 14'h2b5a;
   logic [31:0]          rdata;
   logic                 rvalid, run, srst, abrt, prel;
   logic [9:0]           lidx;
   logic [1:0]           frame_list_size;
   int                   errors = 0;
   int                   n_checks = 0;
   // Row: capability, size written, size expected back
   logic [4:0] rows [5] = '{5'b10101, 5'b11010, 5'b11110, 5'b00010, 5'b10000};
   always #2 clock_i = ~clock_i;
   hcs_cmd_status #(.RST_CYCLES(4)) hcs_cmd_status_inst (
      .clock_i(clock_i), .nrst_i(nrst_i), .reg_req_i(req),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
      .programmable_list_capable_i(cap), .status_event_i(evt),
      .host_system_error_i(host_system_error),
      .sched_status_i(hcs_pkg::hcs_sched_type'(3'h5)),
      .pipeline_idle_i(idle), .frame_index_i(fidx),
      .frame_list_index_o(lidx), .frame_list_size_o(frame_list_size),
      .schedule_run_o(run), .soft_reset_o(srst),
      .abort_transfer_o(abrt), .port_release_o(prel));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      #1 req = '{1'b1, 1'b0, a, d};
      @(posedge clock_i);
      #1 req.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock_i);
      #1 req = '{1'b0, 1'b1, a, 32'h0};
      @(posedge clock_i);
      #1 req.rd = 1'b0;
      chk({31'h0, rvalid}, 32'h1);
      chk(rdata, e);
   endtask
   function automatic logic [31:0] exp_idx(input logic [1:0] s);
      case (s)
         2'h1: exp_idx = {23'h0, fidx[11:3]};
         2'h2: exp_idx = {24'h0, fidx[10:3]};
         default: exp_idx = {22'h0, fidx[12:3]};
      endcase
   endfunction
   task automatic stop_test;
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      #20000;
      errors++;
      stop_test;
   end
   initial
   begin
      repeat (10) @(posedge clock_i);
      #1 nrst_i = 1'b1;
      rd(8'h20, 32'h0);
      rd(8'h24, 32'hb000);
      foreach (rows[i])
      begin
         cap = rows[i][4];
         wr(8'h20, {28'h0, rows[i][3:2], 2'h0});
         rd(8'h20, {28'h0, rows[i][1:0], 2'h0});
         chk({22'h0, lidx}, exp_idx(rows[i][1:0]));
         chk({30'h0, frame_list_size}, {30'h0, rows[i][1:0]});
      end
      @(posedge clock_i);
      #1 evt = 6'h05;
      @(posedge clock_i);
      #1 evt = 6'h0;
      rd(8'h24, 32'hb005);
      wr(8'h24, 32'h1);
      rd(8'h24, 32'hb004);
      wr(8'h24, 32'h0);
      rd(8'h24, 32'hb004);
      rd(8'h30, 32'h0);
      wr(8'h20, 32'h1);
      chk({31'h0, run}, 32'h1);
      rd(8'h24, 32'ha004);
      idle = 1'b0;
      wr(8'h20, 32'h0);
      chk({31'h0, run}, 32'h0);
      repeat (3) @(posedge clock_i);
      rd(8'h24, 32'ha004);
      idle = 1'b1;
      repeat (3) @(posedge clock_i);
      rd(8'h24, 32'hb004);
      wr(8'h20, 32'h1);
      host_system_error = 1'b1;
      @(posedge clock_i);
      #1 host_system_error = 1'b0;
      chk({31'h0, run}, 32'h0);
      repeat (3) @(posedge clock_i);
      rd(8'h24, 32'hb014);
      wr(8'h20, 32'h2);
      chk({29'h0, srst, abrt, prel}, 32'h7);
      wr(8'h20, 32'h0);
      rd(8'h20, 32'h2);
      repeat (6) @(posedge clock_i);
      rd(8'h20, 32'h0);
      rd(8'h24, 32'hb000);
      stop_test;
   end
endmodule
`default_nettype wire
